// file: acfg_regs.v
// Configuration registers zero and one of the ADC with serial read/write access
`timescale 1ns/1ps
`default_nettype none
`include "acfg_consts.vh"

module acfg_regs (
  input wire core_clk,
  input wire nrst,
  input wire sclk,
  input wire cs_n,
  input wire din,
  output reg dout,
  output reg dout_oe,
  output reg [3:0] input_selector,
  output reg [2:0] gain_code,
  output reg amplifier_skip,
  output reg [2:0] rate_select,
  output reg [1:0] op_mode,
  output reg conversion_repeat,
  output reg temperature_sense_enable,
  output reg burnout_source_enable,
  output reg amplifier_active,
  output reg monitor_select,
  output reg filter_restart
);

  // ==========================================================
  // Local definitions
  localparam ST_CMD = 2'h0;
  localparam ST_WR = 2'h1;
  localparam ST_RD = 2'h2;

  reg [7:0] input_gain_config_r;
  reg [7:0] rate_mode_config_r;
  reg [1:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [6:0] rx_r;
  reg [7:0] tx_r;
  reg [1:0] addr_r;
  reg [1:0] left_r;
  reg [7:0] stage0_r;
  reg [7:0] stage1_r;
  reg hit0_r;
  reg hit1_r;
  reg sclk_prev_r;
  wire [2:0] pin_s;
  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  wire sclk_fall;
  wire sclk_rise;
  wire [7:0] rx_byte;
  wire byte_done;
  wire [7:0] cfg0_nxt;
  wire [7:0] cfg1_nxt;
  wire commit;

  // Register contents as seen by a read command
  function [7:0] rd_reg;
    input [1:0] addr;
    input [7:0] r0;
    input [7:0] r1;
    begin
      case (addr)
        `ACFG_OFS_INPUT_GAIN: rd_reg = r0;
        `ACFG_OFS_RATE_MODE: rd_reg = r1;
        default: rd_reg = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisation and serial clock edges
  acfg_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({sclk, cs_n, din}),
    .sync_out(pin_s)
  );

  assign sclk_s = pin_s[2];
  assign cs_n_s = pin_s[1];
  assign din_s = pin_s[0];
  assign sclk_fall = sclk_prev_r & ~sclk_s & ~cs_n_s;
  assign sclk_rise = ~sclk_prev_r & sclk_s & ~cs_n_s;
  assign rx_byte = {rx_r, din_s};
  assign byte_done = sclk_fall && (bit_cnt_r == `ACFG_BIT_LAST);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_s;
    end
  end

  // ==========================================================
  // Command decode and byte transfer
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_CMD;
      bit_cnt_r <= 3'h0;
      rx_r <= 7'h00;
      tx_r <= 8'h00;
      addr_r <= 2'h0;
      left_r <= 2'h0;
      stage0_r <= 8'h00;
      stage1_r <= 8'h00;
      hit0_r <= 1'b0;
      hit1_r <= 1'b0;
    end else if (cs_n_s) begin
      // Deselect abandons any command part way through
      state_r <= ST_CMD;
      bit_cnt_r <= 3'h0;
      hit0_r <= 1'b0;
      hit1_r <= 1'b0;
    end else if (sclk_fall) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_r <= rx_byte[6:0];
      if (byte_done) begin
        case (state_r)
          ST_CMD: begin
            addr_r <= rx_byte[3:2];
            left_r <= rx_byte[1:0];
            hit0_r <= 1'b0;
            hit1_r <= 1'b0;
            if (rx_byte[7:4] == `ACFG_OP_WRITE) begin
              state_r <= ST_WR;
            end else if (rx_byte[7:4] == `ACFG_OP_READ) begin
              state_r <= ST_RD;
              tx_r <= rd_reg(rx_byte[3:2], input_gain_config_r, rate_mode_config_r);
            end else begin
              state_r <= ST_CMD;
            end
          end
          ST_WR: begin
            // Bytes are staged; registers change only on the last byte
            if (addr_r == `ACFG_OFS_INPUT_GAIN) begin
              stage0_r <= rx_byte;
              hit0_r <= 1'b1;
            end
            if (addr_r == `ACFG_OFS_RATE_MODE) begin
              stage1_r <= rx_byte;
              hit1_r <= 1'b1;
            end
            addr_r <= addr_r + 2'h1;
            left_r <= left_r - 2'h1;
            if (left_r == 2'h0) begin
              state_r <= ST_CMD;
              hit0_r <= 1'b0;
              hit1_r <= 1'b0;
            end
          end
          ST_RD: begin
            // No command is decoded until every requested byte is out
            addr_r <= addr_r + 2'h1;
            left_r <= left_r - 2'h1;
            tx_r <= rd_reg(addr_r + 2'h1, input_gain_config_r, rate_mode_config_r);
            if (left_r == 2'h0) begin
              state_r <= ST_CMD;
            end
          end
          default: begin
            state_r <= ST_CMD;
          end
        endcase
      end
    end else if (sclk_rise && state_r == ST_RD) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Register update on the final falling edge of a write
  assign commit = byte_done && !cs_n_s && state_r == ST_WR && left_r == 2'h0;
  assign cfg0_nxt = (addr_r == `ACFG_OFS_INPUT_GAIN) ? rx_byte :
                    (hit0_r ? stage0_r : input_gain_config_r);
  assign cfg1_nxt = (addr_r == `ACFG_OFS_RATE_MODE) ? rx_byte :
                    (hit1_r ? stage1_r : rate_mode_config_r);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      input_gain_config_r <= `ACFG_RST_INPUT_GAIN;
      rate_mode_config_r <= `ACFG_RST_RATE_MODE;
      filter_restart <= 1'b0;
    end else begin
      filter_restart <= commit;
      if (commit) begin
        // Every bit stored verbatim, unused codes included
        input_gain_config_r <= cfg0_nxt;
        rate_mode_config_r <= cfg1_nxt;
      end
    end
  end

  // ==========================================================
  // Serial output: MSB first on rising edges during a read
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dout <= 1'b1;
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= ~cs_n_s;
      if (cs_n_s) begin
        dout <= 1'b1;
      end else if (sclk_rise) begin
        dout <= (state_r == ST_RD) ? tx_r[7] : 1'b1;
      end
    end
  end

  // ==========================================================
  // Field outputs and their effect on the converter
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      input_selector <= 4'h0;
      gain_code <= 3'h0;
      amplifier_skip <= 1'b0;
      rate_select <= 3'h0;
      op_mode <= 2'h0;
      conversion_repeat <= 1'b0;
      temperature_sense_enable <= 1'b0;
      burnout_source_enable <= 1'b0;
      amplifier_active <= 1'b1;
      monitor_select <= 1'b0;
    end else begin
      input_selector <= input_gain_config_r[`ACFG_SEL_HI:`ACFG_SEL_LO];
      gain_code <= input_gain_config_r[`ACFG_GAIN_HI:`ACFG_GAIN_LO];
      amplifier_skip <= input_gain_config_r[`ACFG_SKIP_BIT];
      rate_select <= rate_mode_config_r[`ACFG_RATE_HI:`ACFG_RATE_LO];
      op_mode <= rate_mode_config_r[`ACFG_MODE_HI:`ACFG_MODE_LO];
      conversion_repeat <= rate_mode_config_r[`ACFG_REPEAT_BIT];
      temperature_sense_enable <= rate_mode_config_r[`ACFG_TSENSE_BIT];
      burnout_source_enable <= rate_mode_config_r[`ACFG_BURN_BIT];
      if (rate_mode_config_r[`ACFG_TSENSE_BIT]) begin
        // Register zero has no effect on amplifier_active or monitor_select while sensing temperature
        amplifier_active <= 1'b1;
        monitor_select <= 1'b0;
      end else if (input_gain_config_r[`ACFG_SEL_HI:`ACFG_SEL_LO] == `ACFG_SEL_REF_MON ||
                   input_gain_config_r[`ACFG_SEL_HI:`ACFG_SEL_LO] == `ACFG_SEL_SUP_MON) begin
        amplifier_active <= 1'b0;
        monitor_select <= 1'b1;
      end else begin
        amplifier_active <= ~(input_gain_config_r[`ACFG_SKIP_BIT] &&
          input_gain_config_r[`ACFG_GAIN_HI:`ACFG_GAIN_LO] <= `ACFG_GAIN_SKIP_MAX);
        monitor_select <= 1'b0;
      end
    end
  end

endmodule // acfg_regs

`default_nettype wire

// file: acfg_consts.vh
// Constants for the ADC configuration register bank
`ifndef ACFG_CONSTS_VH
`define ACFG_CONSTS_VH

// Register offsets (2-bit address field of the commands)
`define ACFG_OFS_INPUT_GAIN 2'h0
`define ACFG_OFS_RATE_MODE 2'h1

// Reset values
`define ACFG_RST_INPUT_GAIN 8'h00
`define ACFG_RST_RATE_MODE 8'h00

// Field positions, input_gain_config
`define ACFG_SEL_HI 7
`define ACFG_SEL_LO 4
`define ACFG_GAIN_HI 3
`define ACFG_GAIN_LO 1
`define ACFG_SKIP_BIT 0

// Field positions, rate_mode_config
`define ACFG_RATE_HI 7
`define ACFG_RATE_LO 5
`define ACFG_MODE_HI 4
`define ACFG_MODE_LO 3
`define ACFG_REPEAT_BIT 2
`define ACFG_TSENSE_BIT 1
`define ACFG_BURN_BIT 0

// Input selector codes of note
`define ACFG_SEL_REF_MON 4'hc
`define ACFG_SEL_SUP_MON 4'hd
// Highest gain code that may run without the amplifier (gain 4)
`define ACFG_GAIN_SKIP_MAX 3'h2

// Command opcodes, upper nibble of the command byte
`define ACFG_OP_READ 4'h2
`define ACFG_OP_WRITE 4'h4

// Serial byte length in bits, minus one
`define ACFG_BIT_LAST 3'h7

`endif

// file: acfg_sync.v
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none

module acfg_sync (
  input wire core_clk,
  input wire nrst,
  input wire [2:0] async_in,
  output reg [2:0] sync_out
);

  reg [2:0] meta_r;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // Reset to the idle pin levels: clock low, select and data high
      meta_r <= 3'h3;
      sync_out <= 3'h3;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // acfg_sync

`default_nettype wire

// file: acfg_regs_props.sv
// Port assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module acfg_regs_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic [3:0] input_selector,
  input wire logic [2:0] gain_code,
  input wire logic amplifier_skip,
  input wire logic [2:0] rate_select,
  input wire logic [1:0] op_mode,
  input wire logic conversion_repeat,
  input wire logic temperature_sense_enable,
  input wire logic burnout_source_enable,
  input wire logic amplifier_active,
  input wire logic monitor_select,
  input wire logic filter_restart
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic mon_w = (input_selector == 4'hc) || (input_selector == 4'hd);
  wire logic amp_w = temperature_sense_enable | (!mon_w & !(amplifier_skip & (gain_code <= 3'h2)));
  sequence quiet_s;
    !filter_restart [*3];
  endsequence
  sequence frame_s;
    $fell(cs_n);
  endsequence
  sel_hold_a: assert property (!$past(filter_restart) |->
    $stable({input_selector, gain_code, amplifier_skip})) else $error("reg0 moved without write");
  rate_hold_a: assert property (!$past(filter_restart) |-> $stable({rate_select, op_mode,
    conversion_repeat, temperature_sense_enable, burnout_source_enable})) else $error("reg1 moved");
  pulse_once_a: assert property (filter_restart |=> !filter_restart)
    else $error("restart pulse too long");
  pulse_frame_a: assert property (filter_restart |-> dout_oe)
    else $error("restart outside frame");
  amp_path_a: assert property (quiet_s |-> amplifier_active == amp_w)
    else $error("amplifier use wrong");
  mon_path_a: assert property (quiet_s |-> monitor_select == (mon_w & !temperature_sense_enable))
    else $error("monitor select wrong");
  oe_idle_a: assert property (cs_n [*4] |-> !dout_oe && dout)
    else $error("output active while deselected");
  oe_start_a: assert property (frame_s |-> ##[1:5] dout_oe)
    else $error("output not enabled in frame");
endmodule // acfg_regs_props
bind acfg_regs acfg_regs_props chk (.core_clk, .nrst, .cs_n, .dout, .dout_oe, .input_selector,
  .gain_code, .amplifier_skip, .rate_select, .op_mode, .conversion_repeat,
  .temperature_sense_enable, .burnout_source_enable, .amplifier_active, .monitor_select,
  .filter_restart);
`default_nettype wire

// file: acfg_host.sv
// Serial host model issuing register commands
`timescale 1ns/1ps
`default_nettype none
module acfg_host (
  input wire logic core_clk,
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic open_frame();
    tick(1);
    cs_n = 1'b0;
    tick(8);
  endtask
  // Change on rise, sample on fall, MSB first
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nbits; i--) begin
      sclk = 1'b1;
      din = tx[i];
      tick(4);
      sclk = 1'b0;
      tick(3);
      rx[i] = dout;
      tick(1);
    end
  endtask
  // Clock stands low between frames, data line toggled
  task automatic close_frame();
    tick(8);
    cs_n = 1'b1;
    din = ~din;
    tick(8);
  endtask
endmodule // acfg_host
`default_nettype wire

// file: acfg_regs_test.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "acfg_consts.vh"
module acfg_regs_test;
  logic core_clk, nrst;
  wire logic sclk, cs_n, din, dout, dout_oe, amplifier_skip, conversion_repeat;
  wire logic temperature_sense_enable, burnout_source_enable, amplifier_active;
  wire logic monitor_select, filter_restart;
  wire logic [3:0] input_selector;
  wire logic [2:0] gain_code, rate_select;
  wire logic [1:0] op_mode;
  wire logic dout_pin = dout_oe ? dout : 1'b1;
  int error_cnt = 0;
  int num_checks = 0;
  int pulse_cnt = 0;
  logic [7:0] b0, b1;
  logic [7:0] t0 [5] = '{8'h81, 8'hc0, 8'hd5, 8'hf7, 8'h05};
  logic [7:0] t1 [5] = '{8'h00, 8'h4d, 8'hb2, 8'hf9, 8'h60};
  acfg_regs uut (.core_clk, .nrst, .sclk, .cs_n, .din, .dout, .dout_oe, .input_selector,
    .gain_code, .amplifier_skip, .rate_select, .op_mode, .conversion_repeat,
    .temperature_sense_enable, .burnout_source_enable, .amplifier_active, .monitor_select,
    .filter_restart);
  acfg_host host (.core_clk, .sclk, .cs_n, .din, .dout(dout_pin));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (filter_restart === 1'b1) pulse_cnt++;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d0, input logic [7:0] d1,
    input logic [1:0] nn);
    host.open_frame();
    host.shift({`ACFG_OP_WRITE, a, nn}, 8, b0);
    host.shift(d0, 8, b0);
    if (nn != 2'h0) host.shift(d1, 8, b0);
    host.close_frame();
  endtask
  task automatic rd(input logic [1:0] a);
    host.open_frame();
    host.shift({`ACFG_OP_READ, a, 2'h1}, 8, b0);
    host.shift(8'h00, 8, b0);
    host.shift(8'h00, 8, b1);
    host.close_frame();
  endtask
  task automatic check_all(input logic [7:0] e0, input logic [7:0] e1);
    logic mon;
    mon = (e0[7:4] == 4'hc) || (e0[7:4] == 4'hd);
    chk("reg0 fields", e0, {input_selector, gain_code, amplifier_skip});
    chk("reg1 fields", e1, {rate_select, op_mode, conversion_repeat,
      temperature_sense_enable, burnout_source_enable});
    chk("amplifier", {7'h0, e1[1] | (!mon & !(e0[0] & (e0[3:1] <= 3'h2)))},
      {7'h0, amplifier_active});
    chk("monitor", {7'h0, mon & !e1[1]}, {7'h0, monitor_select});
    rd(2'h0);
    chk("reg0 read", e0, b0);
    chk("reg1 read", e1, b1);
  endtask
  initial begin
    nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    host.tick(3);
    check_all(8'h00, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(2'h0, t0[i], t1[i], 2'h1);
      chk("restarts", 8'(i + 1), 8'(pulse_cnt));
      check_all(t0[i], t1[i]);
    end
    wr(2'h0, 8'h5a, 8'h00, 2'h0);
    check_all(8'h5a, 8'h60);
    $display("field test done");
    wr(2'h2, 8'hff, 8'hff, 2'h1);
    rd(2'h3);
    chk("reserved read", 8'h00, b0);
    chk("wrapped read", 8'h5a, b1);
    pulse_cnt = 0;
    host.open_frame();
    host.shift({`ACFG_OP_WRITE, 2'h1, 2'h0}, 8, b0);
    host.shift(8'h3c, 5, b0);
    host.close_frame();
    host.open_frame();
    host.shift(8'h1b, 8, b0);
    host.shift(8'hff, 8, b0);
    host.close_frame();
    chk("abort restarts", 8'h00, 8'(pulse_cnt));
    check_all(8'h5a, 8'h60);
    $display("reserved and abort test done");
    nrst = 1'b0;
    host.tick(2);
    nrst = 1'b1;
    host.tick(3);
    check_all(8'h00, 8'h00);
    $display("second reset test done");
    wrap_up();
  end
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule // acfg_regs_test
`default_nettype wire
